/* verilog/sdc_cache.v */
/*
 scalar data cache: 8 pages x 8 lines x 16 words of 64 bits, byte parity,
 logical tags, write-through stores, line fill, bypass loads, apb control.
 assumes the cpu holds a request until ack, memory returns fill words in
 order from word 0 with mem_rvalid, and accepts a request when mem_ack.
*/
`timescale 1ns/100ps
`include "sdc_defines.vh"
module sdc_cache #(
    parameter ADDR_W = 40
) (
    input wire sys_clk,
    input wire rst,
    input wire req_valid,
    input wire req_write,
    input wire [1:0] req_kind,
    input wire req_bypass,
    input wire req_cacheable,
    input wire [ADDR_W-1:0] req_addr,
    input wire [63:0] req_wdata,
    output reg req_ack,
    output reg [63:0] req_rdata,
    output reg mem_req,
    output reg mem_write,
    output reg mem_line,
    output reg [ADDR_W-1:0] mem_addr,
    output reg [63:0] mem_wdata,
    input wire mem_ack,
    input wire mem_rvalid,
    input wire [63:0] mem_rdata,
    input wire job_cache_permit,
    input wire cache_on_instr,
    input wire cache_off_flush_instr,
    input wire parity_int_en,
    output reg parity_int,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr
);
    // req_kind: 0 address, 1 scalar, 2 b/t register, 3 vector
    localparam ST_IDLE = 2'd0;
    localparam ST_MREQ = 2'd1;
    localparam ST_FILL = 2'd2;
    localparam ST_DONE = 2'd3;

    localparam KIND_A = 2'd0;
    localparam KIND_S = 2'd1;
    localparam KIND_BT = 2'd2;
    localparam KIND_V = 2'd3;

    localparam TAG_W = `SDC_TAG_HI - `SDC_TAG_LO + 1;
    // storage arrays; slice s holds bits {4s+32..}, {4s..}; section picks even/odd
    reg [63:0] data_mem [0:`SDC_PAGES*`SDC_LINES*`SDC_WORDS-1];
    reg [7:0] par_mem [0:`SDC_PAGES*`SDC_LINES*`SDC_WORDS-1];
    reg [TAG_W-1:0] tag_q [0:`SDC_PAGES-1];
    reg [`SDC_PAGES-1:0] page_valid_q;
    reg [`SDC_LINES-1:0] line_valid_q [0:`SDC_PAGES-1];
    reg [2:0] repl_q;
    reg enable_q;
    reg [1:0] state_q;
    reg [2:0] fpage_q;
    reg [3:0] fcnt_q;
    reg fkill_q;
    reg fnewpage_q;
    reg fault_flag_q;
    reg [11:0] fault_code_q;
    reg [31:0] ctrl_q;
    integer i;

    function [7:0] byte_par;
        input [63:0] w;
        integer k;
        begin
            for (k = 0; k < 8; k = k + 1) begin
                byte_par[k] = ^w[8*k +: 8];
            end
        end
    endfunction

    // slice index from first failing byte and memory section
    function [11:0] slice_code;
        input [7:0] bad;
        input [2:0] sect;
        integer k;
        reg [3:0] s;
        begin
            s = 4'h0;
            for (k = 7; k >= 0; k = k - 1) begin
                if (bad[k]) begin
                    s = {k[1:0], 2'b00};
                end
            end
            s[0] = (sect >= 3'd2) && (sect <= 3'd5);
            slice_code = `SDC_CODE_BASE + {8'h00, s};
        end
    endfunction

    // flat storage index of one word
    function [9:0] cell_index;
        input [2:0] page;
        input [2:0] line;
        input [3:0] word;
        begin
            cell_index = {page, line, word};
        end
    endfunction

    // line field of a word address
    function [2:0] line_of;
        input [ADDR_W-1:0] a;
        begin
            line_of = a[`SDC_LINE_HI:`SDC_LINE_LO];
        end
    endfunction

    // true for the three decoded apb offsets
    function reg_known;
        input [11:0] a;
        begin
            reg_known = (a == `SDC_REG_CTRL) || (a == `SDC_REG_STAT) ||
                (a == `SDC_REG_FAULT);
        end
    endfunction

    wire [TAG_W-1:0] rtag = req_addr[`SDC_TAG_HI:`SDC_TAG_LO];
    wire [2:0] rline = line_of(req_addr);
    wire [3:0] rword = req_addr[`SDC_WORD_HI:`SDC_WORD_LO];
    wire as_kind = (req_kind == KIND_A) || (req_kind == KIND_S);
    // request classes outside the cached load path
    wire as_store = req_write && as_kind;
    wire other_store = req_write && !as_kind;
    wire bypass_load = req_bypass && as_kind && !req_write;

    wire use_cache = enable_q && job_cache_permit && req_cacheable;
    reg pm;
    reg [2:0] pidx;
    always @* begin
        pm = 1'b0;
        pidx = 3'd0;
        for (i = 0; i < `SDC_PAGES; i = i + 1) begin
            if (page_valid_q[i] && tag_q[i] == rtag) begin
                pm = 1'b1;
                pidx = i[2:0];
            end
        end
    end
    wire hit = pm && line_valid_q[pidx][rline];
    // hit lookup result and its stored parity
    wire [9:0] hidx = cell_index(pidx, rline, rword);
    wire [63:0] hdata = data_mem[hidx];
    wire [7:0] hbad = byte_par(hdata) ^ par_mem[hidx];
    wire cached_load = as_kind && !req_write && !req_bypass && use_cache;
    // fill in progress targets this line
    wire [2:0] fline = line_of(mem_addr);
    wire busy_line = (state_q != ST_IDLE) && (fpage_q == pidx) && (fline == rline);
    wire [9:0] fidx = cell_index(fpage_q, fline, fcnt_q);
    wire fill_last = (fcnt_q == 4'hf);
    wire apb_wr = psel && penable && pready && pwrite;


    always @(posedge sys_clk) begin
        if (rst) begin
            page_valid_q <= {`SDC_PAGES{1'b0}};
            for (i = 0; i < `SDC_PAGES; i = i + 1) begin
                line_valid_q[i] <= {`SDC_LINES{1'b0}};
                tag_q[i] <= {TAG_W{1'b0}};
            end
            repl_q <= 3'd0;
            enable_q <= 1'b0;
            state_q <= ST_IDLE;
            fpage_q <= 3'd0;
            fcnt_q <= 4'h0;
            fkill_q <= 1'b0;
            fnewpage_q <= 1'b0;
            req_ack <= 1'b0;
            req_rdata <= 64'h0;
            mem_req <= 1'b0;
            mem_write <= 1'b0;
            mem_line <= 1'b0;
            mem_addr <= {ADDR_W{1'b0}};
            mem_wdata <= 64'h0;
            parity_int <= 1'b0;
            fault_flag_q <= 1'b0;
            fault_code_q <= 12'h000;
        end else begin
            req_ack <= 1'b0;
            parity_int <= 1'b0;
            if (cache_on_instr) begin
                enable_q <= 1'b1;
            end
            if (cache_off_flush_instr) begin
                enable_q <= 1'b0;
                page_valid_q <= {`SDC_PAGES{1'b0}};
                for (i = 0; i < `SDC_PAGES; i = i + 1) begin
                    line_valid_q[i] <= {`SDC_LINES{1'b0}};
                end
                fkill_q <= state_q != ST_IDLE;
            end
            case (state_q)
                ST_IDLE: begin
                    if (req_valid && !req_ack && !cache_off_flush_instr) begin
                        if (cached_load && hit && hbad == 8'h00) begin
                            req_rdata <= hdata;
                            req_ack <= 1'b1;
                        end else if (cached_load && hit) begin
                            // parity fault: flag, report, refetch from memory
                            fault_flag_q <= 1'b1;
                            fault_code_q <= slice_code(hbad, req_addr[2:0]);
                            parity_int <= parity_int_en;
                            line_valid_q[pidx][rline] <= 1'b0;
                            mem_req <= 1'b1;
                            mem_write <= 1'b0;
                            mem_line <= 1'b0;
                            mem_addr <= req_addr;
                            state_q <= ST_MREQ;
                        end else if (cached_load) begin
                            fnewpage_q <= !pm;
                            if (!pm) begin
                                tag_q[repl_q] <= rtag;
                                page_valid_q[repl_q] <= 1'b0;
                                line_valid_q[repl_q] <= {`SDC_LINES{1'b0}};
                                fpage_q <= repl_q;
                                repl_q <= repl_q + 3'd1;
                            end else begin
                                fpage_q <= pidx;
                            end
                            fkill_q <= 1'b0;
                            fcnt_q <= 4'h0;
                            mem_req <= 1'b1;
                            mem_write <= 1'b0;
                            mem_line <= 1'b1;
                            mem_addr <= {req_addr[ADDR_W-1:`SDC_LINE_LO], 4'h0};
                            state_q <= ST_MREQ;
                        end else begin
                            if (as_store && use_cache && hit) begin
                                data_mem[hidx] <= req_wdata;
                                par_mem[hidx] <= byte_par(req_wdata);
                            end
                            if (hit && use_cache && (other_store || bypass_load)) begin
                                line_valid_q[pidx][rline] <= 1'b0;
                            end
                            if (busy_line && (other_store || bypass_load)) begin
                                fkill_q <= 1'b1;
                            end
                            // other loads and stores go straight to memory
                            mem_req <= 1'b1;
                            mem_write <= req_write; // full word to all sections
                            mem_line <= 1'b0;
                            mem_addr <= req_addr;
                            mem_wdata <= req_wdata;
                            state_q <= ST_MREQ;
                        end
                    end
                end
                ST_MREQ: begin
                    if (mem_ack) begin
                        mem_req <= 1'b0;
                        if (mem_write) begin
                            req_ack <= 1'b1;
                            state_q <= ST_DONE;
                        end else begin
                            state_q <= ST_FILL;
                        end
                    end
                end
                ST_FILL: begin
                    if (mem_rvalid) begin
                        if (!mem_line) begin
                            req_rdata <= mem_rdata;
                            req_ack <= 1'b1;
                            state_q <= ST_DONE;
                        end else begin
                            data_mem[fidx] <= mem_rdata;
                            par_mem[fidx] <= byte_par(mem_rdata);
                            if (fcnt_q == req_addr[`SDC_WORD_HI:`SDC_WORD_LO]) begin
                                req_rdata <= mem_rdata;
                            end
                            fcnt_q <= fcnt_q + 4'h1;
                            if (fill_last) begin
                                if (!fkill_q && !cache_off_flush_instr) begin
                                    line_valid_q[fpage_q][fline] <= 1'b1;
                                    page_valid_q[fpage_q] <= 1'b1;
                                end
                                req_ack <= 1'b1;
                                state_q <= ST_DONE;
                            end
                        end
                    end
                end
                ST_DONE: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
            if (apb_wr && paddr == `SDC_REG_FAULT) begin
                fault_flag_q <= 1'b0;
            end
        end
    end

    // apb read mux over the three decoded registers
    wire [31:0] stat_word = {22'h0, state_q, enable_q, page_valid_q[6:0]};
    wire [31:0] fault_word = {19'h0, fault_flag_q, fault_code_q};
    reg [31:0] rd_mux;
    always @* begin
        case (paddr)
            `SDC_REG_CTRL: begin
                rd_mux = ctrl_q;
            end
            `SDC_REG_STAT: begin
                rd_mux = stat_word;
            end
            `SDC_REG_FAULT: begin
                rd_mux = fault_word;
            end
            default: begin
                rd_mux = 32'h0;
            end
        endcase
    end

    // apb slave: no wait states, pready high in the first access cycle, ctrl is plain storage, fault write clears flag
    always @(posedge sys_clk) begin
        if (rst) begin
            ctrl_q <= `SDC_CTRL_RST;
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !pready;
            pslverr <= 1'b0;
            if (psel && !pready) begin
                pslverr <= !reg_known(paddr);
                prdata <= rd_mux;
            end
            if (apb_wr && paddr == `SDC_REG_CTRL) begin
                ctrl_q <= pwdata;
            end
        end
    end
endmodule

/* verilog/sdc_defines.vh */
/*
 scalar data cache constants: geometry, address fields, register map, fault codes.
 assumes inclusion by the cache top module only.
*/
`ifndef SDC_DEFINES_VH
`define SDC_DEFINES_VH
`define SDC_PAGES 8
`define SDC_LINES 8
`define SDC_WORDS 16
`define SDC_TAG_LO 7
`define SDC_TAG_HI 39
`define SDC_LINE_LO 4
`define SDC_LINE_HI 6
`define SDC_WORD_LO 0
`define SDC_WORD_HI 3
`define SDC_REG_CTRL 12'h000
`define SDC_REG_STAT 12'h004
`define SDC_REG_FAULT 12'h008
`define SDC_CTRL_RST 32'h00000000
`define SDC_CODE_BASE 12'o0030
`define SDC_SLICES 16
`endif

/* verification/sdc_cache_checker.sv */
/*
 checker for the scalar data cache top ports.
 assumes binding to every sdc_cache instance, one clock, sync reset.
*/
`timescale 1ns/100ps
module sdc_cache_checker #(
    parameter ADDR_W = 40
) (
    input wire sys_clk,
    input wire rst,
    input wire req_valid,
    input wire [1:0] req_kind,
    input wire req_bypass,
    input wire req_cacheable,
    input wire job_cache_permit,
    input wire req_ack,
    input wire mem_req,
    input wire mem_write,
    input wire mem_line,
    input wire [ADDR_W-1:0] mem_addr,
    input wire mem_ack,
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pslverr,
    input wire [31:0] prdata
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_ack_one_cycle: assert property (req_ack |=> !req_ack)
        else $error("req_ack longer than one cycle");
    a_ack_has_cause: assert property (req_ack |-> $past(req_valid))
        else $error("req_ack without request");
    a_mreq_held: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
        else $error("mem request dropped early");
    a_fill_line_base: assert property (mem_req && mem_line |-> mem_addr[3:0] == 4'h0)
        else $error("fill not on line base");
    a_store_no_fill: assert property (mem_req && mem_write |-> !mem_line)
        else $error("store started a fill");
    a_other_no_fill: assert property (mem_req && req_valid && req_kind[1] |-> !mem_line)
        else $error("b t v request filled");
    a_bypass_single: assert property (mem_req && req_valid && req_bypass |-> !mem_line)
        else $error("bypass load filled");
    a_map_bypass: assert property (mem_req && req_valid && !req_cacheable |-> !mem_line)
        else $error("non cacheable filled");
    a_permit_off: assert property (mem_req && req_valid && !job_cache_permit |-> !mem_line)
        else $error("job without permit filled");
    a_apb_ready: assert property (psel && !penable |=> pready)
        else $error("pready late");
    a_err_zero: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("error read not zero");
endmodule
bind sdc_cache sdc_cache_checker #(.ADDR_W(ADDR_W)) sdc_cache_checker_inst (.*);

/* verification/sdc_mem_model.sv */
/*
 memory model behind the cache: ack pulse, then one or sixteen words on a read, none on a write.
 assumes the cache holds mem_req and its qualifiers until mem_ack.
*/
`timescale 1ns/100ps
module sdc_mem_model (
    input wire sys_clk,
    input wire rst,
    input wire mem_req,
    input wire mem_write,
    input wire mem_line,
    input wire [39:0] mem_addr,
    input wire [63:0] mem_wdata,
    output reg mem_ack,
    output reg mem_rvalid,
    output reg [63:0] mem_rdata
);
    logic [63:0] mem_q [logic [39:0]];
    logic slow_q = 0;
    logic [39:0] a;
    function automatic logic [63:0] rd(input logic [39:0] x);
        return mem_q.exists(x) ? mem_q[x] : {24'hc3a5e1, x};
    endfunction
    initial begin
        mem_ack = 0;
        mem_rvalid = 0;
        mem_rdata = 0;
    end
    always begin
        @(posedge sys_clk);
        if (!rst && mem_req === 1'b1) begin
            a = mem_addr;
            repeat (slow_q ? 3 : 0) @(posedge sys_clk);
            mem_ack <= 1;
            @(posedge sys_clk);
            if (mem_write) mem_q[a] = mem_wdata;
            mem_ack <= 0;
            // words in order from mem_addr (the line base for a fill), no snoop traffic
            for (int i = 0; !mem_write && i < (mem_line ? 16 : 1); i++) begin
                mem_rvalid <= 1;
                mem_rdata <= rd(a + i);
                @(posedge sys_clk);
                if (slow_q) begin
                    mem_rvalid <= 0;
                    mem_rdata <= ~rd(a + i);
                    @(posedge sys_clk);
                end
            end
            mem_rvalid <= 0;
            slow_q = !slow_q;
        end
    end
endmodule

/* verification/tb_top.sv */
/*
 self-checking bench for the scalar data cache.
 assumes sdc_cache, sdc_mem_model and the bound checker.
*/
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end
module tb_top;
    reg sys_clk = 0, rst = 1, req_valid = 0, req_write = 0, req_bypass = 0;
    reg req_cacheable = 1, job_cache_permit = 1, parity_int_en = 1;
    reg cache_on_instr = 0, cache_off_flush_instr = 0, psel = 0, penable = 0, pwrite = 0;
    reg [1:0] req_kind = 0;
    reg [39:0] req_addr = 0;
    reg [63:0] req_wdata = 0;
    reg [11:0] paddr = 0;
    reg [31:0] pwdata = 0;
    wire req_ack, mem_req, mem_write, mem_line, mem_ack, mem_rvalid, pready, pslverr;
    wire parity_int;
    wire [63:0] req_rdata, mem_wdata, mem_rdata;
    wire [39:0] mem_addr;
    wire [31:0] prdata;
    int n_mismatch = 0, n_compared = 0, n_fill = 0, cyc = 0;
    logic [63:0] lq[$], aq[$], e, dd, v;
    logic [63:0] sh [logic [39:0]];
    logic [39:0] x, la [8];
    logic [31:0] lf = 32'h6c1c85ad;
    sdc_cache sdc_cache_inst (.*);
    sdc_mem_model sdc_mem_model_inst (.*);
    function automatic logic [31:0] rnd();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf;
    endfunction
    function automatic logic [63:0] ex(input logic [39:0] a);
        return sh.exists(a) ? sh[a] : {24'hc3a5e1, a};
    endfunction
    task close_out();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial forever #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            close_out();
        end
        if (mem_req && mem_ack && mem_line) n_fill++;
        if (!rst) `CHK("parity_int", 1'b0, parity_int)
        if (req_ack && !req_write) begin
            e = lq.pop_front();
            `CHK("req_rdata", e, req_rdata)
        end
        if (psel && penable && pready && !pwrite) begin
            e = aq.pop_front();
            `CHK("prdata", e[31:0], prdata & e[63:32])
        end
    end
    task apb(input w, input [11:0] a, input [31:0] d, input [31:0] m, input err);
        @(posedge sys_clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge sys_clk);
        penable <= 1;
        if (!w) aq.push_back({m, d & m});
        do @(posedge sys_clk); while (pready !== 1'b1);
        `CHK("pslverr", err, pslverr)
        psel <= 0;
        penable <= 0;
    endtask
    task acc(input [1:0] k, input w, input b, input [39:0] a, input [63:0] d, input int nf);
        int f;
        f = n_fill;
        @(posedge sys_clk);
        {req_valid, req_kind, req_write, req_bypass} <= {1'b1, k, w, b};
        req_addr <= a;
        req_wdata <= d;
        if (!w) lq.push_back(d);
        do @(posedge sys_clk); while (req_ack !== 1'b1);
        req_valid <= 0;
        if (w) sh[a] = d;
        `CHK("fills", nf, n_fill - f)
    endtask
    task pl(input on);
        @(posedge sys_clk);
        {cache_on_instr, cache_off_flush_instr} <= {on, !on};
        @(posedge sys_clk);
        {cache_on_instr, cache_off_flush_instr} <= 2'b00;
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        rst <= 0;
        apb(0, 12'h000, 32'h0, 32'hffffffff, 0);
        v = rnd();
        apb(1, 12'h000, v[31:0], 0, 0);
        apb(0, 12'h000, v[31:0], 32'hffffffff, 0);
        apb(0, 12'h008, 32'h0, 32'hffffffff, 0);
        apb(0, 12'h004, 32'h0, 32'h80, 0);
        apb(0, 12'h010, 32'h0, 32'hffffffff, 1);
        pl(1);
        apb(0, 12'h004, 32'h80, 32'h80, 0);
        x = 40'h0012345600;
        acc(0, 0, 0, x, ex(x), 1);
        acc(1, 0, 0, x + 5, ex(x + 5), 0);
        acc(0, 0, 0, x + 16, ex(x + 16), 1);
        dd = {rnd(), rnd()};
        acc(1, 1, 0, x + 5, dd, 0);
        acc(0, 0, 0, x + 5, dd, 0);
        acc(0, 1, 0, x + 200, ~dd, 0);
        acc(0, 0, 0, x + 200, ~dd, 1);
        v = ~ex(x + 6);
        sdc_mem_model_inst.mem_q[x + 6] = v;
        acc(0, 0, 0, x + 6, ex(x + 6), 0);
        sh[x + 6] = v;
        acc(0, 0, 1, x + 6, v, 0);
        acc(1, 0, 1, x + 6, v, 0);
        acc(1, 0, 0, x + 6, v, 1);
        acc(2, 1, 0, x + 16, dd, 0);
        acc(0, 0, 0, x + 16, dd, 1);
        acc(3, 1, 0, x, ~dd, 0);
        acc(3, 1, 0, x + 9000, dd, 0);
        acc(0, 0, 0, x, ~dd, 1);
        acc(3, 0, 0, x + 1000, ex(x + 1000), 0);
        acc(0, 0, 0, x + 1000, ex(x + 1000), 1);
        acc(2, 0, 0, x, ex(x), 0);
        req_cacheable <= 0;
        acc(0, 0, 0, x + 3000, ex(x + 3000), 0);
        req_cacheable <= 1;
        job_cache_permit <= 0;
        acc(1, 0, 0, x + 4000, ex(x + 4000), 0);
        job_cache_permit <= 1;
        pl(0);
        apb(0, 12'h004, 32'h0, 32'h80, 0);
        acc(0, 0, 0, x, ex(x), 0);
        pl(1);
        acc(0, 0, 0, x, ex(x), 1);
        for (int i = 0; i < 9; i++) acc(0, 0, 0, 40'h8000000000 + i * 128, ex(40'h8000000000 + i * 128), 1);
        acc(0, 0, 0, 40'h8000000400, ex(40'h8000000400), 0);
        for (int i = 0; i < 8; i++) la[i] = 40'h4000000000 + i * 16 + rnd() % 16;
        for (int j = 0; j < 2; j++)
            for (int i = 0; i < 8; i++) acc(j, 0, 0, la[i], ex(la[i]), j == 0);
        close_out();
    end
endmodule
